// ---- pkg/tav_pkg.sv ----
package tav_pkg;
   localparam int     CLK_HZ          = 10_000_000;
   localparam int     KC_TIMEOUT_MIN  = 5;
   localparam longint KC_TIMEOUT_CYC  = longint'(KC_TIMEOUT_MIN) * 60 * longint'(CLK_HZ);

   localparam logic [4:0] ADDR_CTRL   = 5'h00;
   localparam logic [4:0] ADDR_KEN    = 5'h04;
   localparam logic [4:0] ADDR_MAKER  = 5'h08;
   localparam logic [4:0] ADDR_FILL   = 5'h0C;
   localparam logic [4:0] ADDR_STATUS = 5'h10;

   localparam int CTRL_KEN_EN   = 0;
   localparam int CTRL_DEF_KEY  = 1;
   localparam int CTRL_COM_KEY  = 2;
   localparam int CTRL_BLOCK    = 3;
   localparam int CTRL_NEED_LSB = 4;

   localparam logic [7:0]  CTRL_RST  = 8'h30;
   localparam logic [23:0] KEN_RST   = 24'hFFFFFF;
   localparam logic [7:0]  MAKER_RST = 8'h00;

   localparam logic [1:0] CLASS_CREDIT = 2'h0;
   localparam logic [1:0] CLASS_MGMT   = 2'h1;
   localparam logic [1:0] CLASS_UTIL   = 2'h2;
   localparam logic [1:0] CLASS_RSVD   = 2'h3;

   localparam logic [3:0] SUB_KC1 = 4'h3;
   localparam logic [3:0] SUB_KC2 = 4'h4;
   localparam logic [3:0] SUB_KC3 = 4'h8;
   localparam logic [3:0] SUB_KC4 = 4'h9;

   typedef enum logic [1:0] {
      AUTH_OK = 2'h0, AUTH_CRC = 2'h1, AUTH_MAKER = 2'h2, AUTH_BOTH = 2'h3
   } tav_auth_t;

   typedef enum logic [2:0] {
      VAL_VALID = 3'h0, VAL_SKIPPED = 3'h1, VAL_REPEAT = 3'h2,
      VAL_STALE = 3'h3, VAL_EXPIRED = 3'h6, VAL_DEFAULT = 3'h7
   } tav_valid_t;

   typedef enum logic [4:0] {
      FIN_ACCEPT = 5'h00, FIN_KC1 = 5'h01, FIN_KC2 = 5'h02, FIN_KC3 = 5'h03,
      FIN_KC4 = 5'h04, FIN_CHECKSUM = 5'h05, FIN_MAKER = 5'h06, FIN_STALE = 5'h07,
      FIN_REPEAT = 5'h08, FIN_EXPIRED = 5'h09, FIN_DEFAULT = 5'h0A,
      FIN_OVERFLOW = 5'h0B, FIN_KEY_RULE = 5'h0C, FIN_STRUCTURE = 5'h0D,
      FIN_RANGE = 5'h0E, FIN_UNSUPPORTED = 5'h0F
   } tav_final_t;

   typedef struct packed {
      logic [1:0]  tclass;
      logic [3:0]  token_subtype;
      logic [23:0] token_identifier;
      logic [7:0]  maker_identifier;
      logic [39:0] data;
      logic [15:0] crc;
      logic        store_clear_flag;
      logic        credit_overflow;
      logic        key_rule_bad;
      logic        structure_bad;
      logic        range_bad;
      logic        unsupported;
   } tav_token_t;

   typedef struct packed {
      tav_auth_t  auth_outcome;
      tav_valid_t validity_outcome;
      tav_final_t final_outcome;
      logic       erase;
   } tav_result_t;
endpackage

// ---- hdl/tav_core.sv ----
`timescale 1ns/1ps
// Contract
// R1: Class 0/2 authentic when checksum matches
// R2: Class 1 needs checksum and maker identifier
// R3: Key change tokens skip identifier checks
// R4: Identifier below store minimum is stale
// R5: Identifier already stored is a repeat
// R6: Identifier above expiry number is expired
// R7: Class 0 rejected under default key
// R8: Default key still accepts class 1, key change
// R9: Keep at least fifty identifiers stored
// R10: Full store replaces smallest identifier
// R11: Key change leaves store unless clear flag
// R12: Refuse tokens older than manufacture date; code compares with smallest stored identifier, so an empty store refuses none
// R13: Producer preloads store with manufacture date
// R14: Common key erases accepted class 0/2
// R15: Last key change token is erased
// R16: Accept only when every check passes
// R17: Partial key change reports part indication
// R18: Credit overflow rejects token
// R19: Key rule violation rejects token
// R20: Structure or range fault rejects token
// R21: Missing function rejects token
// R22: Tamper or limit state accepts by default
// R23: Partial key change times out
// R24: Authentication gates identifier validation
module tav_core
   import tav_pkg::*;
#(
   parameter int          DEPTH      = 50,
   parameter logic [15:0] CRC_POLY   = 16'h8005,
   parameter logic [15:0] CRC_INIT   = 16'h0000,
   parameter logic [31:0] KC_TIMEOUT = 32'(KC_TIMEOUT_CYC)
) (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               ce,
   input  wire logic [4:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               tok_valid,
   input  wire tav_pkg::tav_token_t tok,
   input  wire logic               tamper_pin,
   input  wire logic               power_limit_pin,
   output logic                    res_valid,
   output tav_pkg::tav_result_t    res
);
   import tav_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);
   localparam int IW = $clog2(DEPTH);

   logic [1:0]       rst_sync_q;
   logic             rst_n;
   logic [1:0]       pin_s1_q;
   logic [1:0]       pin_s2_q;
   logic [7:0]       ctrl_q;
   logic [23:0]      ken_q;
   logic [7:0]       maker_q;
   logic             waitreq_q;
   logic [31:0]      rdata_q;
   logic [31:0]      rdata_d;
   logic [23:0]      tid_mem_q [DEPTH];
   logic [DEPTH-1:0] used_q;
   logic [DEPTH-1:0] hit;
   logic [3:0]       kc_mask_q;
   logic [31:0]      kc_timer_q;
   logic             res_valid_q;
   tav_result_t      res_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 2'b00;
         pin_s2_q <= 2'b00;
      end else if (ce) begin
         pin_s1_q <= {power_limit_pin, tamper_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   // Register bus decode
   wire bus_take   = ce & (avs_read | avs_write) & ~waitreq_q;
   wire bus_wr     = bus_take & avs_write;
   wire sel_ctrl   = (avs_address == ADDR_CTRL);
   wire sel_ken    = (avs_address == ADDR_KEN);
   wire sel_maker  = (avs_address == ADDR_MAKER);
   wire sel_fill   = (avs_address == ADDR_FILL);
   wire sel_status = (avs_address == ADDR_STATUS);
   wire fill_we    = bus_wr & sel_fill;

   // Store search
   logic [IW-1:0] min_idx;
   logic [23:0]   min_val;
   logic          any_used;
   logic [IW-1:0] free_idx;
   logic          has_free;
   logic [CW-1:0] store_cnt;

   always_comb begin
      min_idx   = '0;
      min_val   = 24'h000000;
      any_used  = 1'b0;
      free_idx  = '0;
      has_free  = 1'b0;
      store_cnt = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (used_q[i]) begin
            store_cnt = store_cnt + CW'(1);
            if (!any_used || tid_mem_q[i] < min_val) begin
               min_val = tid_mem_q[i];
               min_idx = IW'(i);
            end
            any_used = 1'b1;
         end else if (!has_free) begin
            free_idx = IW'(i);
            has_free = 1'b1;
         end
      end
   end

   always_comb begin
      rdata_d = 32'h00000000;
      if (sel_ctrl) begin
         rdata_d = {24'h000000, ctrl_q};
      end else if (sel_ken) begin
         rdata_d = {8'h00, ken_q};
      end else if (sel_maker) begin
         rdata_d = {24'h000000, maker_q};
      end else if (sel_status) begin
         rdata_d = {12'h000, 10'(store_cnt), kc_mask_q, 1'b0, res_q.final_outcome};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitreq_q <= 1'b1;
         rdata_q   <= 32'h00000000;
         ctrl_q    <= CTRL_RST;
         ken_q     <= KEN_RST;
         maker_q   <= MAKER_RST;
      end else if (ce) begin
         waitreq_q <= ~((avs_read | avs_write) & waitreq_q);
         if ((avs_read | avs_write) & waitreq_q) begin
            rdata_q <= rdata_d;
         end
         if (bus_wr & sel_ctrl) begin
            ctrl_q <= avs_writedata[7:0];
         end
         if (bus_wr & sel_ken) begin
            ken_q <= avs_writedata[23:0];
         end
         if (bus_wr & sel_maker) begin
            maker_q <= avs_writedata[7:0];
         end
      end
   end

   function automatic logic [15:0] crc16(input logic [39:0] d);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 39; i >= 0; i--) begin
         c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // Token classification
   wire is_c1  = (tok.tclass == CLASS_MGMT);
   wire is_c0  = (tok.tclass == CLASS_CREDIT);
   wire is_c02 = is_c0 | (tok.tclass == CLASS_UTIL);
   wire [3:0] st = tok.token_subtype;
   wire is_kc  = (tok.tclass == CLASS_UTIL) &
                 ((st == SUB_KC1) | (st == SUB_KC2) | (st == SUB_KC3) | (st == SUB_KC4));
   wire [1:0] kc_part = (st == SUB_KC1) ? 2'd0 : (st == SUB_KC2) ? 2'd1 :
                        (st == SUB_KC3) ? 2'd2 : 2'd3;
   wire [3:0] kc_need = ctrl_q[CTRL_NEED_LSB +: 4];
   wire [3:0] kc_next = kc_mask_q | (4'h1 << kc_part);
   wire       kc_done = (kc_need != 4'h0) & ((kc_next & kc_need) == kc_need);

   // Authentication
   wire crc_ok   = (crc16(tok.data) == tok.crc);                              // R1
   wire maker_ok = (tok.maker_identifier == maker_q);
   wire [1:0] auth_bits = {is_c1 & ~maker_ok, ~crc_ok};                       // R2
   wire auth_ok  = (auth_bits == 2'b00);

   // Identifier validation
   wire tid_check = auth_ok & is_c02 & ~is_kc;                                // R3 R24
   wire stale     = any_used & (tok.token_identifier < min_val);              // R4 R12
   wire repeat_hit = |hit;                                                    // R5
   wire expired   = ctrl_q[CTRL_KEN_EN] & (tok.token_identifier > ken_q);     // R6
   wire def_key   = ctrl_q[CTRL_DEF_KEY] & is_c0;                             // R7 R8

   tav_valid_t val_d;
   always_comb begin
      val_d = VAL_VALID;
      if (!auth_ok) begin
         val_d = VAL_SKIPPED;                                                 // R24
      end else if (tid_check) begin
         if (stale) begin
            val_d = VAL_STALE;
         end else if (repeat_hit) begin
            val_d = VAL_REPEAT;
         end else if (expired) begin
            val_d = VAL_EXPIRED;
         end else if (def_key) begin
            val_d = VAL_DEFAULT;
         end
      end
   end

   // Execution outcome
   wire gated    = ctrl_q[CTRL_BLOCK] & (|pin_s2_q);                          // R22
   wire unsup    = tok.unsupported | (tok.tclass == CLASS_RSVD) | gated;      // R21
   wire pre_ok   = auth_ok & (val_d == VAL_VALID) & ~tok.structure_bad & ~tok.range_bad & ~unsup;

   tav_final_t fin_d;
   always_comb begin
      fin_d = FIN_ACCEPT;
      if (auth_bits[0]) begin
         fin_d = FIN_CHECKSUM;
      end else if (auth_bits[1]) begin
         fin_d = FIN_MAKER;
      end else if (val_d == VAL_STALE) begin
         fin_d = FIN_STALE;
      end else if (val_d == VAL_REPEAT) begin
         fin_d = FIN_REPEAT;
      end else if (val_d == VAL_EXPIRED) begin
         fin_d = FIN_EXPIRED;
      end else if (val_d == VAL_DEFAULT) begin
         fin_d = FIN_DEFAULT;
      end else if (tok.structure_bad) begin
         fin_d = FIN_STRUCTURE;                                               // R20
      end else if (tok.range_bad) begin
         fin_d = FIN_RANGE;                                                   // R20
      end else if (unsup) begin
         fin_d = FIN_UNSUPPORTED;                                             // R21
      end else if (is_c0 & tok.credit_overflow) begin
         fin_d = FIN_OVERFLOW;                                                // R18
      end else if (is_kc & kc_done & tok.key_rule_bad) begin
         fin_d = FIN_KEY_RULE;                                                // R19
      end else if (is_kc & ~kc_done) begin
         fin_d = tav_final_t'(5'(kc_part) + 5'h01);                           // R17
      end
   end

   wire take      = ce & tok_valid;
   wire accept    = (fin_d == FIN_ACCEPT);                                    // R16
   wire store_we  = take & accept & is_c02 & ~is_kc;
   wire store_clr = take & accept & is_kc & tok.store_clear_flag;             // R11
   wire [IW-1:0] wr_idx = has_free ? free_idx : min_idx;                      // R10
   wire erase_d   = accept & ((is_c02 & ~is_kc & ctrl_q[CTRL_COM_KEY]) | is_kc); // R14 R15
   wire kc_expire = (kc_mask_q != 4'h0) & (kc_timer_q >= KC_TIMEOUT - 32'h1);

   // Identifier store, one entry per slot
   for (genvar g = 0; g < DEPTH; g++) begin : g_store
      assign hit[g] = used_q[g] & (tid_mem_q[g] == tok.token_identifier);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            used_q[g]    <= 1'b0;
            tid_mem_q[g] <= 24'h000000;
         end else if (ce) begin
            if (fill_we) begin
               used_q[g]    <= 1'b1;                                          // R13
               tid_mem_q[g] <= avs_writedata[23:0];
            end else if (store_clr) begin
               used_q[g] <= 1'b0;                                             // R11
            end else if (store_we && wr_idx == IW'(g)) begin
               used_q[g]    <= 1'b1;                                          // R9 R10
               tid_mem_q[g] <= tok.token_identifier;
            end
         end
      end
   end

   // Key change set progress and timeout
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kc_mask_q  <= 4'h0;
         kc_timer_q <= 32'h00000000;
      end else if (ce) begin
         if (tok_valid & is_kc & pre_ok) begin
            kc_mask_q <= kc_done ? 4'h0 : kc_next;
         end else if (kc_expire) begin
            kc_mask_q <= 4'h0;                                                // R23
         end
         if (kc_mask_q == 4'h0 || kc_expire) begin
            kc_timer_q <= 32'h00000000;
         end else begin
            kc_timer_q <= kc_timer_q + 32'h1;                                 // R23
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_valid_q <= 1'b0;
         res_q       <= '{AUTH_OK, VAL_VALID, FIN_ACCEPT, 1'b0};
      end else if (ce) begin
         res_valid_q <= tok_valid;
         if (tok_valid) begin
            res_q <= '{tav_auth_t'(auth_bits), val_d, fin_d, erase_d};
         end
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = waitreq_q;
   assign res_valid       = res_valid_q;
   assign res             = res_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_crc_fail_flag: assert property (take && !crc_ok |=> res_valid && res.auth_outcome[0]) // R1
      else $error("checksum mismatch not flagged");
   a_maker_check: assert property (take && is_c1 && !maker_ok |=> res.auth_outcome[1]) // R2
      else $error("maker identifier mismatch not flagged");
   a_kc_no_tid: assert property (take && is_kc |=> res.validity_outcome inside {VAL_VALID, VAL_SKIPPED}) // R3
      else $error("key change token got identifier check");
   a_stale_reject: assert property (take && tid_check && stale |=> res.final_outcome == FIN_STALE) // R4
      else $error("stale token not rejected");
   a_repeat_reject: assert property (take && tid_check && !stale && repeat_hit |=> res.final_outcome == FIN_REPEAT) // R5
      else $error("repeat token not rejected");
   a_expired_rej: assert property (take && tid_check && !stale && !repeat_hit && expired // R6
                                   |=> res.validity_outcome == VAL_EXPIRED)
      else $error("expired key not flagged");
   a_default_key: assert property (take && ctrl_q[CTRL_DEF_KEY] && is_c0 // R7
                                   |=> res.final_outcome != FIN_ACCEPT)
      else $error("class 0 accepted under default key");
   a_store_grow: assert property (store_we && has_free && !fill_we |=> store_cnt == $past(store_cnt) + CW'(1)) // R9
      else $error("store did not grow");
   a_full_replace: assert property (store_we && !has_free && !fill_we // R10
                                    |=> store_cnt == $past(store_cnt)
                                    && tid_mem_q[$past(min_idx)] == $past(tok.token_identifier))
      else $error("full store replacement failed");
   a_store_clear: assert property (store_clr && !fill_we |=> used_q == '0) // R11
      else $error("store not cleared by key change");
   a_old_no_erase: assert property (take && tid_check && stale |=> !res.erase) // R14
      else $error("stale token erased");
   a_kc_store_keep: assert property (take && is_kc && !store_clr && !fill_we |=> $stable(used_q)) // R11
      else $error("key change altered store");
   a_accept_needs: assert property (res_valid && res.final_outcome == FIN_ACCEPT // R16
                                    |-> res.auth_outcome == AUTH_OK && res.validity_outcome == VAL_VALID)
      else $error("accept without passing checks");
   a_kc_last_erase: assert property (take && is_kc && pre_ok && kc_done && !tok.key_rule_bad // R15
                                     |=> res.final_outcome == FIN_ACCEPT && res.erase)
      else $error("last key change token not accepted and erased");
   a_kc_part_report: assert property (take && is_kc && pre_ok && !kc_done // R17
                                      |=> res.final_outcome inside {FIN_KC1, FIN_KC2, FIN_KC3, FIN_KC4} && !res.erase)
      else $error("partial key change not reported by part");
   a_key_rule_rej: assert property (take && is_kc && pre_ok && kc_done && tok.key_rule_bad // R19
                                    |=> res.final_outcome == FIN_KEY_RULE)
      else $error("key rule violation not rejected");
   a_format_reject: assert property (take && auth_ok && val_d == VAL_VALID && tok.structure_bad // R20
                                     |=> res.final_outcome == FIN_STRUCTURE)
      else $error("structure fault not rejected");
   a_range_reject: assert property (take && auth_ok && val_d == VAL_VALID && !tok.structure_bad && tok.range_bad // R20
                                    |=> res.final_outcome == FIN_RANGE)
      else $error("range fault not rejected");
   a_unsup_reject: assert property (take && auth_ok && val_d == VAL_VALID && !tok.structure_bad && !tok.range_bad // R21
                                    && unsup |=> res.final_outcome == FIN_UNSUPPORTED)
      else $error("unsupported token not rejected");
   a_erase_only_ok: assert property (res_valid && res.erase |-> res.final_outcome == FIN_ACCEPT) // R14
      else $error("erase on non accepted token");
   a_overflow_rej: assert property (take && pre_ok && is_c0 && tok.credit_overflow // R18
                                    |=> res.final_outcome == FIN_OVERFLOW)
      else $error("overflow not rejected");
   a_kc_timeout: assert property (ce && kc_expire && !tok_valid |=> kc_mask_q == 4'h0 && kc_timer_q == 32'h0) // R23
      else $error("key change timeout missed");
endmodule

// ---- tb/tav_carrier.sv ----
`timescale 1ns/1ps
module tav_carrier (
   input  wire logic            clk,
   output logic                 tok_valid,
   output tav_pkg::tav_token_t  tok
);
   import tav_pkg::*;

   initial begin
      tok_valid = 1'b0;
      tok       = '0;
   end

   // One-cycle token pulse after an idle gap; lines show the inverse once released
   task automatic send(input tav_token_t t, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok       <= t;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok       <= ~t;
   endtask
endmodule

// ---- tb/token_auth_validation_tb_top.sv ----
`timescale 1ns/1ps
module token_auth_validation_tb_top;
   import tav_pkg::*;
   logic        clk;
   logic        arst_n;
   logic        ce;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        tok_valid;
   tav_token_t  tok;
   tav_token_t  t;
   logic        tamper_pin;
   logic        power_limit_pin;
   logic        res_valid;
   tav_result_t res;
   tav_result_t e;
   tav_result_t exp_q[$];
   tav_final_t  fins[4] = '{FIN_OVERFLOW, FIN_STRUCTURE, FIN_RANGE, FIN_UNSUPPORTED};
   int          fails;
   int          checked;
   logic [15:0] rng;
   logic [31:0] rd;
   logic [7:0]  maker;

   tav_core #(.KC_TIMEOUT(32'd20)) u_dut (
      .clk(clk), .arst_n(arst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid), .tok(tok), .tamper_pin(tamper_pin),
      .power_limit_pin(power_limit_pin), .res_valid(res_valid), .res(res)
   );
   tav_carrier u_car (.clk(clk), .tok_valid(tok_valid), .tok(tok));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [15:0] crc16(input logic [39:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 39; i >= 0; i--) begin
         c = (c[15] ^ d[i]) ? ((c << 1) ^ 16'h8005) : (c << 1);
      end
      return c;
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Avalon master: hold the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_address   <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] ex, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, ex, rd);
   endtask

   task automatic mk(input logic [1:0] c, input logic [3:0] s, input logic [23:0] id, output tav_token_t o);
      rng = lfsr(rng);
      o = '0;
      o.tclass = c;
      o.token_subtype = s;
      o.token_identifier = id;
      o.maker_identifier = maker;
      o.data = {rng[7:0], rng, rng ^ 16'h5A5A};
      o.crc = crc16(o.data);
   endtask

   task automatic run(input tav_token_t o, input tav_auth_t a, input tav_valid_t v, input tav_final_t f,
                      input logic er);
      tav_result_t r;
      r = '{a, v, f, er};
      exp_q.push_back(r);
      rng = lfsr(rng);
      u_car.send(o, int'(rng[1:0]));
      repeat (2) @(posedge clk);
   endtask

   task automatic tk(input logic [1:0] c, input logic [3:0] s, input logic [23:0] id, input tav_final_t f,
                     input tav_valid_t v, input logic er);
      tav_token_t o;
      mk(c, s, id, o);
      run(o, AUTH_OK, v, f, er);
   endtask

   task automatic tdone(input string nm);
      $display("Test %s done", nm);
   endtask

   task automatic print_verdict();
      $display("Checked %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Scoreboard: oldest expectation against each result pulse
   always @(posedge clk) begin
      if (res_valid === 1'b1) begin
         checked++;
         if (exp_q.size() == 0) begin
            fails++;
            $display("ERROR result expected none seen %h", res);
         end else begin
            e = exp_q.pop_front();
            if (res !== e) begin
               fails++;
               $display("ERROR result expected %h seen %h", e, res);
            end
         end
      end
   end

   initial begin
      #3_000_000;
      fails++;
      $display("ERROR watchdog expected done seen timeout");
      print_verdict();
   end

   initial begin
      {arst_n, ce, avs_address, avs_read, avs_write, avs_writedata, tamper_pin, power_limit_pin} = '0;
      fails = 0;
      checked = 0;
      rng = 16'd55478;
      maker = 8'h00;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      ce     <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(ADDR_CTRL, 32'(CTRL_RST), "ctrl reset");
      rdc(ADDR_KEN, 32'(KEN_RST), "expiry reset");
      rdc(ADDR_MAKER, 32'(MAKER_RST), "maker reset");
      bus(1'b1, 5'h14, 32'hFFFFFFFF);
      rdc(5'h14, 32'h0, "unmapped");
      tdone("registers");
      tk(CLASS_CREDIT, 4'h0, 24'h000050, FIN_ACCEPT, VAL_VALID, 1'b0);
      tk(CLASS_CREDIT, 4'h0, 24'h000050, FIN_REPEAT, VAL_REPEAT, 1'b0);
      mk(CLASS_UTIL, 4'h0, 24'h000060, t);
      t.crc = ~t.crc;
      run(t, AUTH_CRC, VAL_SKIPPED, FIN_CHECKSUM, 1'b0);
      tk(CLASS_UTIL, 4'h0, 24'h000060, FIN_ACCEPT, VAL_VALID, 1'b0);
      tdone("checksum");
      bus(1'b1, ADDR_FILL, 32'h00000100);
      tk(CLASS_CREDIT, 4'h0, 24'h0000FF, FIN_STALE, VAL_STALE, 1'b0);
      tk(CLASS_CREDIT, 4'h0, 24'h000100, FIN_REPEAT, VAL_REPEAT, 1'b0);
      tk(CLASS_CREDIT, 4'h0, 24'h000200, FIN_ACCEPT, VAL_VALID, 1'b0);
      tk(CLASS_CREDIT, 4'h0, 24'h000200, FIN_REPEAT, VAL_REPEAT, 1'b0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("store count", 32'd50, {22'h0, rd[19:10]});
      chk("last outcome", 32'(FIN_REPEAT), {27'h0, rd[4:0]});
      tdone("store");
      bus(1'b1, ADDR_CTRL, 32'h00000034);
      bus(1'b1, ADDR_MAKER, 32'h0000005A);
      maker = 8'h5A;
      tk(CLASS_MGMT, 4'h0, 24'h000010, FIN_ACCEPT, VAL_VALID, 1'b0);
      maker = 8'h00;
      mk(CLASS_MGMT, 4'h0, 24'h000011, t);
      run(t, AUTH_MAKER, VAL_SKIPPED, FIN_MAKER, 1'b0);
      mk(CLASS_MGMT, 4'h0, 24'h000012, t);
      t.crc = ~t.crc;
      run(t, AUTH_BOTH, VAL_SKIPPED, FIN_CHECKSUM, 1'b0);
      tk(CLASS_UTIL, 4'h0, 24'h000210, FIN_ACCEPT, VAL_VALID, 1'b1);
      tk(CLASS_CREDIT, 4'h0, 24'h0000FF, FIN_STALE, VAL_STALE, 1'b0);
      tdone("maker and erase");
      bus(1'b1, ADDR_CTRL, 32'h00000031);
      bus(1'b1, ADDR_KEN, 32'h00000300);
      tk(CLASS_CREDIT, 4'h0, 24'h000300, FIN_ACCEPT, VAL_VALID, 1'b0);
      tk(CLASS_UTIL, 4'h0, 24'h000301, FIN_EXPIRED, VAL_EXPIRED, 1'b0);
      bus(1'b1, ADDR_CTRL, 32'h00000032);
      tk(CLASS_CREDIT, 4'h0, 24'h0002F0, FIN_DEFAULT, VAL_DEFAULT, 1'b0);
      tk(CLASS_UTIL, 4'h0, 24'h0002F1, FIN_ACCEPT, VAL_VALID, 1'b0);
      maker = 8'h5A;
      tk(CLASS_MGMT, 4'h0, 24'h000013, FIN_ACCEPT, VAL_VALID, 1'b0);
      tdone("expiry and default key");
      bus(1'b1, ADDR_CTRL, 32'h00000030);
      for (int i = 0; i < 4; i++) begin
         mk(CLASS_CREDIT, 4'h0, 24'h000310 + 24'(i), t);
         {t.credit_overflow, t.structure_bad, t.range_bad, t.unsupported} = 4'h8 >> i;
         run(t, AUTH_OK, VAL_VALID, fins[i], 1'b0);
      end
      bus(1'b1, ADDR_CTRL, 32'h00000038);
      tamper_pin      <= 1'b1;
      power_limit_pin <= 1'b1;
      repeat (4) @(posedge clk);
      tk(CLASS_CREDIT, 4'h0, 24'h000320, FIN_UNSUPPORTED, VAL_VALID, 1'b0);
      bus(1'b1, ADDR_CTRL, 32'h00000030);
      tk(CLASS_CREDIT, 4'h0, 24'h000320, FIN_ACCEPT, VAL_VALID, 1'b0);
      tamper_pin      <= 1'b0;
      power_limit_pin <= 1'b0;
      tdone("execution faults");
      tk(CLASS_UTIL, SUB_KC1, 24'h000001, FIN_KC1, VAL_VALID, 1'b0);
      tk(CLASS_UTIL, SUB_KC2, 24'h000001, FIN_ACCEPT, VAL_VALID, 1'b1);
      tk(CLASS_CREDIT, 4'h0, 24'h000200, FIN_REPEAT, VAL_REPEAT, 1'b0);
      tk(CLASS_UTIL, SUB_KC1, 24'h000002, FIN_KC1, VAL_VALID, 1'b0);
      tk(CLASS_UTIL, SUB_KC3, 24'h000002, FIN_KC3, VAL_VALID, 1'b0);
      tk(CLASS_UTIL, SUB_KC4, 24'h000002, FIN_KC4, VAL_VALID, 1'b0);
      repeat (30) @(posedge clk);
      tk(CLASS_UTIL, SUB_KC2, 24'h000002, FIN_KC2, VAL_VALID, 1'b0);
      mk(CLASS_UTIL, SUB_KC1, 24'h000002, t);
      t.key_rule_bad = 1'b1;
      run(t, AUTH_OK, VAL_VALID, FIN_KEY_RULE, 1'b0);
      tk(CLASS_UTIL, SUB_KC2, 24'h000003, FIN_KC2, VAL_VALID, 1'b0);
      mk(CLASS_UTIL, SUB_KC1, 24'h000003, t);
      t.store_clear_flag = 1'b1;
      run(t, AUTH_OK, VAL_VALID, FIN_ACCEPT, 1'b1);
      tk(CLASS_CREDIT, 4'h0, 24'h0000FF, FIN_ACCEPT, VAL_VALID, 1'b0);
      tdone("key change");
      repeat (4) @(posedge clk);
      chk("pending results", 32'd0, 32'(exp_q.size()));
      print_verdict();
   end
endmodule
